/* File: shared/adc_seq_defines.svh */
// What this block does
// - each sequence starts at the pointer (the first channel after a set write) and steps up to the last channel
// - after the last channel the pointer wraps back to the first channel
// - equal first and last channel settings sample that one channel repeatedly
// - per-channel differential bit; a differential low channel claims channel+8
// - per-channel range code from eight: four unipolar, four bipolar
// - start source selectable: software command, on-board timer, external pin
// - software source gives exactly one start per command, about 4 kHz at most
// - timer source paces starts at programmable rates up to 500 kHz
// - external pin edges give starts; the source keeps them at 500 kHz or less
// - software picks rising or falling edge of the start event
// - starts accepted only while the gate pin is high; it idles high
// - gate falling mid-conversion lets the current channel finish all samples
// - after the gate returns, the next start continues at the next channel
// - single mode converts one channel, the next in sequence, per start, except that a start on a claimed channel only skips it
// - scan mode converts the whole set per start, paced at the model rate
// - one oversample count 0..255 shared by every channel of the set
// - each channel visit takes one sample plus the oversample count
// - all oversamples of a channel finish before the pointer advances
// - software can route analog ground or the near-10 V reference to the ADC
// - loaded offset and gain correction applied to every result in real time
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// register byte offsets; OFF_CHCFG_HI is matched against address bits 7:6
`define OFF_CTRL      8'h00
`define OFF_CHAN      8'h04
`define OFF_OVERS     8'h08
`define OFF_TMR_DIV   8'h0C
`define OFF_SW_START  8'h10
`define OFF_STATUS    8'h14
`define OFF_CAL_OFF   8'h18
`define OFF_CAL_GAIN  8'h1C
`define OFF_RESULT    8'h20
`define OFF_CHCFG_HI  2'h1

// field positions
`define CTRL_SRC_LSB  0
`define CTRL_FALL_BIT 2
`define CTRL_SCAN_BIT 3
`define CTRL_REF_LSB  4
`define CTRL_CAL_BIT  6
`define CHAN_LAST_LSB 8
`define CHCFG_DIFF    3

// reset values
`define RST_TMR_DIV   32'h0000C350
`define RST_CAL_GAIN  16'h4000
`define RST_CAL_OFF   16'h0000

// timing and gain scaling
`define CLK_KHZ       200000
`define MODEL_KHZ     500
`define TMR_MAX_KHZ   500
`define GAIN_SHIFT    14

`endif

/* File: shared/adc_seq_pkg.sv */
package adc_seq_pkg;

  typedef enum logic [1:0] {SRC_SW, SRC_TIMER, SRC_EXT, SRC_NONE} src_t;
  typedef enum logic [1:0] {REF_INPUT, REF_GROUND, REF_HIGH, REF_OFF} ref_t;
  typedef enum logic [1:0] {S_IDLE, S_LAUNCH, S_WAIT, S_PACE} seq_t;

  typedef struct packed {
    logic       start;
    logic [3:0] chan;
    logic       diff;
    logic [2:0] range;
    ref_t       refsel;
  } conv_req_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  chan;
    logic [11:0] data;
  } result_t;

  typedef struct packed {
    src_t src;
    logic fall;
    logic scan;
    ref_t refsel;
    logic cal_en;
  } ctrl_t;

  typedef struct packed {
    ctrl_t           ctrl;
    logic [3:0]      ch_first;
    logic [3:0]      ch_last;
    logic [7:0]      os_cnt;
    logic [31:0]     tmr_div;
    logic [15:0]     cal_off;
    logic [15:0]     cal_gain;
    logic [15:0][3:0] chcfg;
    logic [7:0]      haddr;
    logic            wr_pend;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic            hresp;
    logic            sw_req;
    logic [31:0]     tmr_cnt;
    logic            tmr_lvl;
    seq_t            seq;
    logic [3:0]      ptr;
    logic [3:0]      scan_first;
    logic [7:0]      smp_cnt;
    logic [11:0]     pace;
    conv_req_t       conv;
    result_t         res;
    logic            busy;
  } state_t;

endpackage : adc_seq_pkg

/* File: design/edge_pick.sv */
`timescale 1ns/1ps
`default_nettype none
module edge_pick (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic clk_en,
  input  wire logic lvl,
  input  wire logic fall_sel,
  output var  logic pulse
);
  logic prev_r;
  logic prev_nxt;

  // one-cycle pulse on the chosen edge of a synchronous level
  always_comb begin
    prev_nxt = lvl;
    pulse    = fall_sel ? (prev_r & ~lvl) : (~prev_r & lvl);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_r <= 1'b0;
    end else if (clk_en) begin
      prev_r <= prev_nxt;
    end
  end
endmodule : edge_pick
`default_nettype wire

/* File: design/adc_seq_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_seq_ctrl #(
  parameter int MODEL_KHZ = `MODEL_KHZ,
  parameter bit HAS_CAL   = 1'b1
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   clk_en,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output var  logic                   hreadyout,
  output var  logic                   hresp,
  output var  logic [31:0]            hrdata,
  input  wire logic                   ext_trig,
  input  wire logic                   start_gate,
  input  wire logic                   adc_done,
  input  wire logic [11:0]            adc_data,
  output var  adc_seq_pkg::conv_req_t conv,
  output var  adc_seq_pkg::result_t   result,
  output var  logic                   busy
);
  // conversion spacing at the model's top rate
  localparam int CONV_CYC = `CLK_KHZ / MODEL_KHZ;
  // timer half period floor keeps the timer at or below its top rate
  localparam int TMR_HALF_MIN = `CLK_KHZ / (2 * `TMR_MAX_KHZ);

  adc_seq_pkg::state_t st_r;
  adc_seq_pkg::state_t st_nxt;
  logic        tmr_edge;
  logic        ext_edge;
  logic        start_evt;
  logic [31:0] rd_word;
  logic [31:0] tmr_half;
  logic [3:0]  ptr_next;
  logic        claimed;
  logic [11:0] corr;

  // timer square wave and external pin share the edge selection
  edge_pick u_tmr_edge (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clk_en   (clk_en),
    .lvl      (st_r.tmr_lvl),
    .fall_sel (st_r.ctrl.fall),
    .pulse    (tmr_edge)
  );

  edge_pick u_ext_edge (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clk_en   (clk_en),
    .lvl      (ext_trig),
    .fall_sel (st_r.ctrl.fall),
    .pulse    (ext_edge)
  );

  // offset then gain, saturated to the 12-bit code range
  function automatic logic [11:0] correct(input logic [11:0] raw,
                                          input logic [15:0] off,
                                          input logic [15:0] gain);
    logic signed [17:0] dif;
    logic signed [34:0] prod;
    logic signed [20:0] sc;
    dif  = $signed({6'h00, raw}) - $signed({{2{off[15]}}, off});
    prod = dif * $signed({1'b0, gain});
    sc   = prod[34:`GAIN_SHIFT];
    if (sc < 0) begin
      return 12'h000;
    end else if (sc > 21'sd4095) begin
      return 12'hFFF;
    end else begin
      return sc[11:0];
    end
  endfunction : correct

  // register read mux, decoded in the address phase
  always_comb begin
    rd_word = 32'h00000000;
    if (haddr[7:0] == `OFF_CTRL) begin
      rd_word[1:0] = st_r.ctrl.src;
      rd_word[`CTRL_FALL_BIT] = st_r.ctrl.fall;
      rd_word[`CTRL_SCAN_BIT] = st_r.ctrl.scan;
      rd_word[`CTRL_REF_LSB +: 2] = st_r.ctrl.refsel;
      rd_word[`CTRL_CAL_BIT] = st_r.ctrl.cal_en;
    end else if (haddr[7:0] == `OFF_CHAN) begin
      rd_word[3:0] = st_r.ch_first;
      rd_word[`CHAN_LAST_LSB +: 4] = st_r.ch_last;
    end else if (haddr[7:0] == `OFF_OVERS) begin
      rd_word[7:0] = st_r.os_cnt;
    end else if (haddr[7:0] == `OFF_TMR_DIV) begin
      rd_word = st_r.tmr_div;
    end else if (haddr[7:0] == `OFF_STATUS) begin
      rd_word[0] = st_r.busy;
      rd_word[1] = start_gate;
      rd_word[7:4] = st_r.ptr;
      rd_word[15:8] = st_r.smp_cnt;
    end else if (haddr[7:0] == `OFF_CAL_OFF) begin
      rd_word[15:0] = st_r.cal_off;
    end else if (haddr[7:0] == `OFF_CAL_GAIN) begin
      rd_word[15:0] = st_r.cal_gain;
    end else if (haddr[7:0] == `OFF_RESULT) begin
      rd_word[11:0] = st_r.res.data;
      rd_word[19:16] = st_r.res.chan;
    end else if (haddr[7:6] == `OFF_CHCFG_HI) begin
      rd_word[3:0] = st_r.chcfg[haddr[5:2]];
    end
  end

  // sequencing helpers
  always_comb begin
    // wrap from the last channel back to the first
    ptr_next = (st_r.ptr == st_r.ch_last) ? st_r.ch_first
                                          : st_r.ptr + 4'h1;
    // an upper channel whose low partner is differential is skipped
    claimed = st_r.ptr[3] & st_r.chcfg[{1'b0, st_r.ptr[2:0]}][`CHCFG_DIFF];
    tmr_half = (st_r.tmr_div < 32'(TMR_HALF_MIN)) ? 32'(TMR_HALF_MIN)
                                                  : st_r.tmr_div;
    corr = (HAS_CAL && st_r.ctrl.cal_en)
           ? correct(adc_data, st_r.cal_off, st_r.cal_gain)
           : adc_data;
    // source select, then the gate
    start_evt = start_gate & (
                ((st_r.ctrl.src == adc_seq_pkg::SRC_SW) & st_r.sw_req) |
                ((st_r.ctrl.src == adc_seq_pkg::SRC_TIMER) & tmr_edge) |
                ((st_r.ctrl.src == adc_seq_pkg::SRC_EXT) & ext_edge));
  end

  // next-state logic
  always_comb begin
    logic adv;
    adv = 1'b0;
    st_nxt = st_r;
    st_nxt.conv.start = 1'b0;
    st_nxt.res.valid = 1'b0;
    st_nxt.sw_req = 1'b0;
    st_nxt.hreadyout = 1'b1;
    st_nxt.hresp = 1'b0;
    st_nxt.wr_pend = 1'b0;

    // bus data phase: write lands one cycle after the address phase
    if (st_r.wr_pend) begin
      if (st_r.haddr == `OFF_CTRL) begin
        st_nxt.ctrl.src = adc_seq_pkg::src_t'(hwdata[1:0]);
        st_nxt.ctrl.fall = hwdata[`CTRL_FALL_BIT];
        st_nxt.ctrl.scan = hwdata[`CTRL_SCAN_BIT];
        st_nxt.ctrl.refsel =
          adc_seq_pkg::ref_t'(hwdata[`CTRL_REF_LSB +: 2]);
        st_nxt.ctrl.cal_en = hwdata[`CTRL_CAL_BIT];
      end else if (st_r.haddr == `OFF_CHAN) begin
        st_nxt.ch_first = hwdata[3:0];
        st_nxt.ch_last = hwdata[`CHAN_LAST_LSB +: 4];
        // a new set restarts at its first channel when idle
        if (st_r.seq == adc_seq_pkg::S_IDLE) begin
          st_nxt.ptr = hwdata[3:0];
          st_nxt.smp_cnt = 8'h00;
        end
      end else if (st_r.haddr == `OFF_OVERS) begin
        st_nxt.os_cnt = hwdata[7:0];
      end else if (st_r.haddr == `OFF_TMR_DIV) begin
        st_nxt.tmr_div = hwdata;
      end else if (st_r.haddr == `OFF_SW_START) begin
        st_nxt.sw_req = 1'b1;
      end else if (st_r.haddr == `OFF_CAL_OFF) begin
        st_nxt.cal_off = hwdata[15:0];
      end else if (st_r.haddr == `OFF_CAL_GAIN) begin
        st_nxt.cal_gain = hwdata[15:0];
      end else if (st_r.haddr[7:6] == `OFF_CHCFG_HI) begin
        st_nxt.chcfg[st_r.haddr[5:2]] = hwdata[3:0];
      end
    end

    // bus address phase; zero wait states, unmapped reads give zero
    if (hsel && htrans[1] && hready) begin
      st_nxt.haddr = haddr[7:0];
      st_nxt.wr_pend = hwrite;
      if (!hwrite) begin
        st_nxt.hrdata = rd_word;
      end
    end

    // timer: square wave whose chosen edge is the start event
    if (st_r.ctrl.src == adc_seq_pkg::SRC_TIMER) begin
      if (st_r.tmr_cnt >= tmr_half - 32'h1) begin
        st_nxt.tmr_cnt = 32'h0;
        st_nxt.tmr_lvl = ~st_r.tmr_lvl;
      end else begin
        st_nxt.tmr_cnt = st_r.tmr_cnt + 32'h1;
      end
    end else begin
      st_nxt.tmr_cnt = 32'h0;
    end

    // pacing counter runs from each conversion start
    if (st_r.pace != 12'h000) begin
      st_nxt.pace = st_r.pace - 12'h001;
    end

    case (st_r.seq)
      adc_seq_pkg::S_IDLE: begin
        // starts arriving while busy are dropped, not queued
        if (start_evt) begin
          st_nxt.seq = adc_seq_pkg::S_LAUNCH;
          st_nxt.scan_first = st_r.ptr;
          st_nxt.smp_cnt = 8'h00;
        end
      end
      adc_seq_pkg::S_LAUNCH: begin
        if (claimed) begin
          adv = 1'b1;
        end else begin
          st_nxt.conv.start = 1'b1;
          st_nxt.conv.chan = st_r.ptr;
          st_nxt.conv.diff = ~st_r.ptr[3] &
                             st_r.chcfg[st_r.ptr][`CHCFG_DIFF];
          st_nxt.conv.range = st_r.chcfg[st_r.ptr][2:0];
          st_nxt.conv.refsel = st_r.ctrl.refsel;
          st_nxt.pace = 12'(CONV_CYC - 1);
          st_nxt.seq = adc_seq_pkg::S_WAIT;
        end
      end
      adc_seq_pkg::S_WAIT: begin
        if (adc_done) begin
          st_nxt.res.valid = 1'b1;
          st_nxt.res.chan = st_r.ptr;
          st_nxt.res.data = corr;
          // one initial sample plus the oversample count
          if (st_r.smp_cnt != st_r.os_cnt) begin
            st_nxt.smp_cnt = st_r.smp_cnt + 8'h01;
            st_nxt.seq = adc_seq_pkg::S_PACE;
          end else begin
            adv = 1'b1;
          end
        end
      end
      adc_seq_pkg::S_PACE: begin
        if (st_r.pace == 12'h000) begin
          st_nxt.seq = adc_seq_pkg::S_LAUNCH;
        end
      end
      default: begin
        st_nxt.seq = adc_seq_pkg::S_IDLE;
      end
    endcase

    // channel done: step the pointer, continue only for a live scan
    if (adv) begin
      st_nxt.smp_cnt = 8'h00;
      st_nxt.ptr = ptr_next;
      // gate low stops here, after the whole channel is done
      if (st_r.ctrl.scan && ptr_next != st_r.scan_first &&
          start_gate) begin
        st_nxt.seq = adc_seq_pkg::S_PACE;
      end else begin
        st_nxt.seq = adc_seq_pkg::S_IDLE;
      end
    end

    st_nxt.busy = (st_nxt.seq != adc_seq_pkg::S_IDLE);
  end

  // the one state register; clk_en low freezes everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.tmr_div <= `RST_TMR_DIV;
      st_r.cal_off <= `RST_CAL_OFF;
      st_r.cal_gain <= `RST_CAL_GAIN;
      st_r.hreadyout <= 1'b1;
      st_r.seq <= adc_seq_pkg::S_IDLE;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  always_comb begin
    hreadyout = st_r.hreadyout;
    hresp = st_r.hresp;
    hrdata = st_r.hrdata;
    conv = st_r.conv;
    result = st_r.res;
    busy = st_r.busy;
  end

endmodule : adc_seq_ctrl
`default_nettype wire

/* File: sim/adc_seq_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_seq_ctrl_checker #(
  parameter int MODEL_KHZ = `MODEL_KHZ
) (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   start_gate,
  input wire logic                   adc_done,
  input wire adc_seq_pkg::conv_req_t conv,
  input wire adc_seq_pkg::result_t   result,
  input wire logic                   busy
);
  localparam int GAP = `CLK_KHZ / MODEL_KHZ;
  logic [11:0] gap_r;
  logic        run_r;
  logic [3:0]  ch_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // start spacing; a busy drop ends the run, so idle gaps are not judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r <= 12'h000;
      run_r <= 1'h0;
      ch_r  <= 4'h0;
    end else begin
      gap_r <= conv.start ? 12'h001 : gap_r + 12'(gap_r != 12'hFFF);
      run_r <= conv.start | (run_r & busy);
      if (conv.start) ch_r <= conv.chan;
    end
  end
  sequence s_go;
    conv.start;
  endsequence
  sequence s_shut;
    !busy && !start_gate;
  endsequence
  a_start_once: assert property (s_go |=> !conv.start)
    else $error("start pulse too long");
  a_gate_shut: assert property (s_shut |-> ##2 !conv.start)
    else $error("start with gate low");
  a_pace_gap: assert property (conv.start && run_r |-> gap_r >= GAP)
    else $error("starts too close");
  a_done_valid: assert property (adc_done && busy |=> result.valid)
    else $error("no result after done");
  a_valid_cause: assert property (result.valid |-> $past(adc_done))
    else $error("result without done");
  a_valid_chan: assert property (result.valid |-> result.chan == ch_r)
    else $error("result channel wrong");
  a_busy_end: assert property ($fell(busy) |-> result.valid)
    else $error("busy fell without result");
  a_diff_low: assert property (conv.start && conv.diff |-> !conv.chan[3])
    else $error("differential on upper channel");
endmodule : adc_seq_ctrl_checker
bind adc_seq_ctrl adc_seq_ctrl_checker #(.MODEL_KHZ(MODEL_KHZ)) i_chk (
  .hclk, .hresetn, .start_gate, .adc_done, .conv, .result, .busy
);
`default_nettype wire

/* File: sim/adc_front_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire adc_seq_pkg::conv_req_t conv,
  input  wire logic [7:0]             lat,
  output var  logic                   adc_done,
  output var  logic [11:0]            adc_data
);
  logic [8:0] cnt_r;
  logic [3:0] ch_r;
  // data carries the channel so visits can be told apart;
  // outside the done cycle the bus inverts each cycle, so the last value returns every other cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r    <= 9'h000;
      ch_r     <= 4'h0;
      adc_done <= 1'h0;
      adc_data <= 12'hFFF;
    end else begin
      adc_done <= cnt_r == 9'h001;
      adc_data <= (cnt_r == 9'h001) ? {ch_r, 8'h5A} : ~adc_data;
      if (conv.start) begin
        cnt_r <= {1'h0, lat} + 9'h001;
        ch_r  <= conv.chan;
      end else if (cnt_r != 9'h000) begin
        cnt_r <= cnt_r - 9'h001;
      end
    end
  end
endmodule : adc_front_model
`default_nettype wire

/* File: sim/adc_seq_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_seq_ctrl_tb;
  logic                   hclk, hresetn, hsel, hwrite, hready, busy;
  logic                   hresp, clk_en;
  logic [1:0]             htrans;
  logic [31:0]            haddr, hwdata, hrdata, v;
  logic                   ext_trig, start_gate, adc_done;
  logic [11:0]            adc_data, sub;
  logic [7:0]             lat;
  logic [15:0]            rq[$];
  adc_seq_pkg::conv_req_t conv, lc;
  adc_seq_pkg::result_t   result;
  int                     fail_count, num_checks;
  adc_seq_ctrl i_dut (
    .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp,
    .hrdata, .ext_trig, .start_gate, .adc_done, .adc_data, .conv,
    .result, .busy
  );
  adc_front_model i_adc (.hclk, .hresetn, .conv, .lat, .adc_done, .adc_data);
  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  // results queue up; the last request is kept for field checks
  always @(posedge hclk) begin
    if (result.valid === 1'h1) rq.push_back({result.chan, result.data});
    if (conv.start === 1'h1) lc <= conv;
  end
  task automatic end_of_test;
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 64);
    if (n >= 64) begin
      fail_count++;
      end_of_test();
    end
  endtask : rdy
  // one single transfer; address held until ready, then the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    v = hrdata;
    chk(32'(hresp), 32'h0);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr
  task automatic go;
    wr(`OFF_SW_START, 32'h1);
  endtask : go
  // bounded wait for the next result, expected raw minus any offset
  task automatic take(input logic [3:0] c);
    int n;
    n = 0;
    while (rq.size() == 0 && n < 5000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 5000) begin
      fail_count++;
      end_of_test();
    end
    chk({16'h0, rq.pop_front()}, {16'h0, c, {c, 8'h5A} - sub});
  endtask : take
  task automatic quiet(input int n);
    repeat (n) @(posedge hclk);
    chk(32'(rq.size()), 32'h0);
  endtask : quiet
  initial begin
    {hresetn, hsel, hwrite, ext_trig} = 4'h0;
    {haddr, hwdata, htrans} = 66'h0;
    start_gate = 1'h1;
    clk_en = 1'h1;
    lat = 8'h14;
    sub = 12'h000;
    fail_count = 0;
    num_checks = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    // reset values, a hole in the map; timer set early, before its use
    bus(1'h0, `OFF_TMR_DIV, 32'h0);
    chk(v, 32'h0000C350);
    bus(1'h0, `OFF_CAL_GAIN, 32'h0);
    chk(v, 32'h00004000);
    bus(1'h0, `OFF_STATUS, 32'h0);
    chk(v & 32'h0000FFF0, 32'h0);
    bus(1'h0, 8'h3C, 32'h0);
    chk(v, 32'h0);
    wr(`OFF_TMR_DIV, 32'hC8);
    // single mode over 2..4 with its wrap; channel 3 on range 5
    wr(8'h4C, 32'h5);
    wr(`OFF_CHAN, 32'h0402);
    for (int i = 0; i < 4; i++) begin
      go();
      take(4'(2 + i % 3));
      chk(lc.range, (i == 1) ? 32'h5 : 32'h0);
    end
    // one channel only, quick converter
    lat <= 8'h01;
    wr(`OFF_CHAN, 32'h0505);
    repeat (2) begin
      go();
      take(4'h5);
    end
    // a start pending while the clock enable is low waits, then runs once
    go();
    clk_en <= 1'h0;
    quiet(300);
    clk_en <= 1'h1;
    take(4'h5);
    // three samples per visit with a slow converter
    lat <= 8'hC8;
    wr(`OFF_OVERS, 32'h2);
    wr(`OFF_CHAN, 32'h0100);
    for (int i = 0; i < 6; i++) begin
      if (i % 3 == 0) go();
      take(4'(i / 3));
    end
    quiet(600);
    // scan 0..9 with channel 0 differential, so 8 is skipped
    lat <= 8'h14;
    wr(`OFF_OVERS, 32'h0);
    wr(8'h40, 32'h8);
    wr(`OFF_CHAN, 32'h0900);
    wr(`OFF_CTRL, 32'h8);
    go();
    for (int c = 0; c < 10; c++) begin
      if (c != 8) take(4'(c));
      if (c == 0) chk(lc.diff, 32'h1);
    end
    quiet(1000);
    wr(8'h40, 32'h0);
    // external pin, rising then falling edge; edges kept 400+ apart
    wr(`OFF_CHAN, 32'h0303);
    for (int f = 0; f < 2; f++) begin
      wr(`OFF_CTRL, {29'h0, f[0], 2'h2});
      ext_trig <= 1'h1;
      if (f == 0) begin
        take(4'h3);
        quiet(400);
      end else begin
        quiet(400);
      end
      ext_trig <= 1'h0;
      if (f == 1) take(4'h3);
      else quiet(400);
    end
    // timer starts, gate shut for three periods, then the next channel
    wr(`OFF_CHAN, 32'h0200);
    wr(`OFF_CTRL, 32'h1);
    take(4'h0);
    take(4'h1);
    start_gate <= 1'h0;
    quiet(1200);
    start_gate <= 1'h1;
    take(4'h2);
    wr(`OFF_CTRL, 32'h3);
    quiet(450);
    // gate falls inside a four-sample visit; the visit still completes
    wr(`OFF_CTRL, 32'h0);
    wr(`OFF_OVERS, 32'h3);
    wr(`OFF_CHAN, 32'h0504);
    go();
    take(4'h4);
    chk(32'(busy), 32'h1);
    start_gate <= 1'h0;
    repeat (3) take(4'h4);
    go();
    quiet(600);
    chk(32'(busy), 32'h0);
    start_gate <= 1'h1;
    wr(`OFF_OVERS, 32'h0);
    go();
    take(4'h5);
    // reference routing, then a 16-count offset correction
    for (int r = 1; r < 3; r++) begin
      wr(`OFF_CTRL, 32'(r) << 4);
      go();
      take(4'(r + 3));
      chk(lc.refsel, 32'(r));
    end
    wr(`OFF_CAL_OFF, 32'h10);
    wr(`OFF_CTRL, 32'h40);
    sub = 12'h010;
    go();
    take(4'h4);
    bus(1'h0, `OFF_RESULT, 32'h0);
    chk(v, 32'h0004044A);
    end_of_test();
  end
endmodule : adc_seq_ctrl_tb
`default_nettype wire
